// ---- design/sic_pkg.sv ----
// Purpose: shared constants and types for the status indicator control
// Assumes: 25 MHz system clock
// Notes:   counts are derived from times in their own units
`default_nettype none
package sic_pkg;
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned BLINK_HZ      = 2;
	localparam int unsigned BLINK_HALF    = CLK_HZ / (BLINK_HZ * 2);
	localparam int unsigned AUTOMATIC_ERROR_RESET_S   = 10;
	localparam int unsigned AUTOMATIC_ERROR_RESET_CYC = AUTOMATIC_ERROR_RESET_S * CLK_HZ;
	localparam int unsigned FREE_S        = 5;
	localparam int unsigned FREE_CYC      = FREE_S * CLK_HZ;
	localparam int unsigned DWELL_MS      = 1500;
	localparam int unsigned DWELL_CYC     = (DWELL_MS * (CLK_HZ / 1000));
	localparam int unsigned CHARS         = 24;

	// screen codes presented to the character generator
	typedef enum logic [3:0] {
		SCR_TYPE      = 4'h0,
		SCR_VERSION   = 4'h1,
		SCR_SERIAL    = 4'h2,
		SCR_NAME      = 4'h3,
		SCR_ADDRESS   = 4'h4,
		SCR_WIRELESS  = 4'h5,
		SCR_NEEDED    = 4'h6,
		SCR_DATE      = 4'h7,
		SCR_SIGNATURE = 4'h8,
		SCR_LEVEL     = 4'h9,
		SCR_FIELD     = 4'hA,
		SCR_WAIT      = 4'hB,
		SCR_TRANSFER  = 4'hC,
		SCR_PING      = 4'hD,
		SCR_MESSAGE   = 4'hE,
		SCR_ERROR     = 4'hF
	} sic_screen_t;

	// error class letter codes
	typedef enum logic [2:0] {
		ERR_INTERNAL = 3'h0,
		ERR_EXTERNAL = 3'h1,
		ERR_USAGE    = 3'h2,
		ERR_INFO     = 3'h3,
		ERR_PARAM    = 3'h4
	} sic_err_class_t;

	localparam logic [7:0] ASCII_F = 8'h46;
	localparam logic [7:0] ASCII_E = 8'h45;
	localparam logic [7:0] ASCII_U = 8'h55;
	localparam logic [7:0] ASCII_I = 8'h49;
	localparam logic [7:0] ASCII_P = 8'h50;
	localparam logic [7:0] ASCII_H = 8'h48;
	localparam logic [7:0] ASCII_V = 8'h56;
	localparam logic [7:0] ASCII_A = 8'h41;
	localparam logic [7:0] ASCII_B = 8'h42;
	localparam logic [7:0] ASCII_D = 8'h44;
endpackage
`default_nettype wire

// ---- design/sic_timer.sv ----
// Purpose: down-counting timer with a one-cycle done pulse
// Assumes: start restarts the count; run low stops it
// Notes:   used for dwell, auto reset and free-field timeouts
`timescale 1ns/1ps
`default_nettype none
module sic_timer #(
	parameter int unsigned COUNT = 25,
	parameter int unsigned W     = 32
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic start,
	input  wire logic run,
	output var  logic done
);
	logic [W-1:0] cnt_q;
	logic         active_q;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_q    <= '0;
			active_q <= 1'b0;
			done     <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_q    <= W'(COUNT - 1);
				active_q <= 1'b1;
			end
			else if (!run)
				active_q <= 1'b0;
			else if (active_q)
			begin
				if (cnt_q == '0)
				begin
					active_q <= 1'b0;
					done     <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // sic_timer
`default_nettype wire

// ---- design/sic_led_channel.sv ----
// Purpose: three LEDs of one protective function
// Assumes: blink is the shared half-period square wave
// Notes:   LEDs are zero while reset (device unlit)
`timescale 1ns/1ps
`default_nettype none
module sic_led_channel (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic blink,
	input  wire logic outputsOn,
	input  wire logic errorActive,
	input  wire logic interlockActive,
	input  wire logic interlockBlocked,
	input  wire logic fieldOccupied,
	input  wire logic linkedEnabled,
	input  wire logic warnInterrupted,
	output var  logic ledRed,
	output var  logic ledGreen,
	output var  logic ledYellow,
	output var  logic ledBlue
);
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ledRed    <= 1'b0;
			ledGreen  <= 1'b0;
		end
		else if (errorActive)
		begin
			ledRed    <= blink;
			ledGreen  <= 1'b0;
		end
		else
		begin
			ledRed    <= !outputsOn;
			ledGreen  <= outputsOn;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			ledYellow <= 1'b0;
		else if (fieldOccupied)
			ledYellow <= blink;
		else
			ledYellow <= interlockActive && interlockBlocked && linkedEnabled;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			ledBlue <= 1'b0;
		else
			ledBlue <= warnInterrupted;
	end
endmodule // sic_led_channel
`default_nettype wire

// ---- design/sic_status_indicator.sv ----
// Purpose: LED and character display control of a safety scanner
// Assumes: status inputs come from logic on sys_clk, pins pass 3 flops
// Notes:   text rendering of a screen is left to a character generator
//
// How it works
// - six LEDs, three per protective function
// - red/green: off, red, blink red, green
// - yellow dark when interlock off or enabled, field free
// - yellow steady when blocked, ready, field free
// - blue shows warning field interrupted
// - normal display shows active field pair
// - unconfigured boot cycles screens, then level
// - configured boot cycles screens, then field pair
// - setup wait, then setup transfer message
// - level screen shows signed H and V
// - ping shows message then device name
// - messages prefixed by function or device
// - error shows class letter then number
// - non-locking error auto resets after 10 s
// - locking error stays until power cycle
// - field free 5 s restores normal display after ping or message
// - display may be blanked or rotated
`timescale 1ns/1ps
`default_nettype none
module sic_status_indicator #(
	parameter int unsigned AUTOMATIC_ERROR_RESET_CYC = sic_pkg::AUTOMATIC_ERROR_RESET_CYC,
	parameter int unsigned FREE_CYC      = sic_pkg::FREE_CYC,
	parameter int unsigned DWELL_CYC     = sic_pkg::DWELL_CYC,
	parameter int unsigned BLINK_HALF    = sic_pkg::BLINK_HALF
) (
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	input  wire logic [1:0]                outputsOn,
	input  wire logic [1:0]                interlockActive,
	input  wire logic [1:0]                interlockBlocked,
	input  wire logic [1:0]                linkedEnabled,
	input  wire logic [1:0]                fieldOccupied,
	input  wire logic [1:0]                warnInterrupted,
	input  wire logic                      startPhase,
	input  wire logic                      configPresent,
	input  wire logic                      setupWait,
	input  wire logic                      setupTransfer,
	input  wire logic                      levelRequest,
	input  wire logic                      pingPulse,
	input  wire logic                      messagePulse,
	input  wire logic                      messageFromDevice,
	input  wire logic                      messageFunctionB,
	input  wire logic                      errorPulse,
	input  wire logic                      errorLocking,
	input  wire logic [2:0]                errorClass,
	input  wire logic [11:0]               errorNumber,
	input  wire logic                      activeFunctionB,
	input  wire logic [6:0]                activePair,
	input  wire logic [3:0]                activeSubIndex,
	input  wire logic signed [7:0]         tiltH,
	input  wire logic signed [7:0]         tiltV,
	input  wire logic                      displayOffCfg,
	input  wire logic                      displayRotateCfg,
	output var  logic [5:0]                ledOn,
	output var  logic [1:0]                ledGreen,
	output var  logic [3:0]                screen,
	output var  logic                      pingNameStep,
	output var  logic [7:0]                prefixChar,
	output var  logic [7:0]                classChar,
	output var  logic [11:0]               codeNumber,
	output var  logic [7:0]                tagH,
	output var  logic [7:0]                tagV,
	output var  logic signed [7:0]         levelH,
	output var  logic signed [7:0]         levelV,
	output var  logic [7:0]                pairLetter,
	output var  logic [6:0]                pairNumber,
	output var  logic [3:0]                pairSubIndex,
	output var  logic                      displayEnable,
	output var  logic                      displayRotate,
	output var  logic                      automaticErrorReset,
	output var  logic                      errorLatched,
	output var  logic                      lockedError
);
	////////////////////////////////////////////////////////////////////
	// class letter lookup, used by the error screen only
	function automatic logic [7:0] classLetter(input logic [2:0] cls);
		unique case (cls)
			sic_pkg::ERR_INTERNAL: classLetter = sic_pkg::ASCII_F;
			sic_pkg::ERR_EXTERNAL: classLetter = sic_pkg::ASCII_E;
			sic_pkg::ERR_USAGE:    classLetter = sic_pkg::ASCII_U;
			sic_pkg::ERR_INFO:     classLetter = sic_pkg::ASCII_I;
			default:               classLetter = sic_pkg::ASCII_P;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// blink prescaler
	logic [23:0] blinkCnt_q;
	logic        blink_q;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			blinkCnt_q <= '0;
			blink_q    <= 1'b0;
		end
		else if (blinkCnt_q == 24'(BLINK_HALF - 1))
		begin
			blinkCnt_q <= '0;
			blink_q    <= !blink_q;
		end
		else
			blinkCnt_q <= blinkCnt_q + 24'h000001;
	end

	////////////////////////////////////////////////////////////////////
	// error state: locking errors hold until reset (power cycle)
	logic errorOn_q;
	logic locked_q;
	logic autoDone;
	logic freeDone;
	logic msgOn_q;
	logic pingOn_q;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			errorOn_q  <= 1'b0;
			locked_q   <= 1'b0;
			classChar  <= 8'h00;
			codeNumber <= 12'h000;
		end
		else if (errorPulse && !locked_q)
		begin
			errorOn_q  <= 1'b1;
			locked_q   <= errorLocking;
			classChar  <= classLetter(errorClass);
			codeNumber <= errorNumber;
		end
		else if (autoDone && !locked_q)
			errorOn_q <= 1'b0;
	end

	// new non-locking error restarts the wait; locking errors never time out
	sic_timer #(.COUNT(AUTOMATIC_ERROR_RESET_CYC), .W(32)) uAuto (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.start   (errorPulse && !errorLocking && !locked_q),
		.run     (errorOn_q && !locked_q),
		.done    (autoDone)
	);

	// auto reset pulse only; suppressed when a new error arrives in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			automaticErrorReset <= 1'b0;
		else
			automaticErrorReset <= autoDone && !locked_q && !errorPulse;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			errorLatched <= 1'b0;
			lockedError  <= 1'b0;
		end
		else
		begin
			errorLatched <= errorOn_q;
			lockedError  <= locked_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// LEDs: bit 0..2 function A (1..3), bit 5..3 function B (6..4)
	logic [1:0] chRed;
	logic [1:0] chGreen;
	logic [1:0] chYellow;
	logic [1:0] chBlue;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gCh
			sic_led_channel uCh (
				.sys_clk          (sys_clk),
				.reset_n          (reset_n),
				.blink            (blink_q),
				.outputsOn        (outputsOn[g]),
				.errorActive      (errorOn_q),
				.interlockActive  (interlockActive[g]),
				.interlockBlocked (interlockBlocked[g]),
				.fieldOccupied    (fieldOccupied[g]),
				.linkedEnabled    (linkedEnabled[g]),
				.warnInterrupted  (warnInterrupted[g]),
				.ledRed           (chRed[g]),
				.ledGreen         (chGreen[g]),
				.ledYellow        (chYellow[g]),
				.ledBlue          (chBlue[g])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ledOn    <= 6'h00;
			ledGreen <= 2'h0;
		end
		else
		begin
			ledOn    <= {chRed[1] | chGreen[1], chYellow[1], chBlue[1],
				chBlue[0], chYellow[0], chRed[0] | chGreen[0]};
			ledGreen <= chGreen;
		end
	end

	////////////////////////////////////////////////////////////////////
	// boot sequence
	logic [3:0] bootIdx_q;
	logic       dwellDone;
	logic       bootDone_q;

	// one count short: the advance lands a cycle after done
	sic_timer #(.COUNT(DWELL_CYC - 1), .W(32)) uDwell (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.start   (startPhase && (dwellDone || bootIdx_q == 4'hF)),
		.run     (startPhase),
		.done    (dwellDone)
	);

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bootIdx_q  <= 4'hF;
			bootDone_q <= 1'b0;
		end
		else if (!startPhase)
		begin
			bootDone_q <= bootIdx_q != 4'hF || bootDone_q;
			bootIdx_q  <= 4'h0;
		end
		else if (bootIdx_q == 4'hF)
			bootIdx_q <= 4'h0;
		else if (dwellDone)
		begin
			if ((configPresent && bootIdx_q == 4'h8) || (!configPresent && bootIdx_q == 4'h6))
				bootIdx_q <= 4'h0;
			else
				bootIdx_q <= bootIdx_q + 4'h1;
		end
	end

	function automatic logic [3:0] bootScreen(input logic [3:0] idx, input logic cfg);
		if (idx < 4'h6)
			bootScreen = idx;
		else if (!cfg)
			bootScreen = sic_pkg::SCR_NEEDED;
		else if (idx == 4'h6)
			bootScreen = sic_pkg::SCR_DATE;
		else if (idx == 4'h7)
			bootScreen = sic_pkg::SCR_SIGNATURE;
		else
			bootScreen = sic_pkg::SCR_LEVEL;
	endfunction

	////////////////////////////////////////////////////////////////////
	// transient screens and the free-field return
	logic allFree;
	assign allFree = fieldOccupied == 2'b00;

	sic_timer #(.COUNT(FREE_CYC), .W(32)) uFree (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.start   (messagePulse || pingPulse || errorPulse || (fieldOccupied != 2'b00)),
		.run     (allFree),
		.done    (freeDone)
	);

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			msgOn_q      <= 1'b0;
			pingOn_q     <= 1'b0;
			pingNameStep <= 1'b0;
			prefixChar   <= 8'h00;
		end
		else
		begin
			if (messagePulse)
			begin
				msgOn_q    <= 1'b1;
				prefixChar <= messageFromDevice ? sic_pkg::ASCII_D :
					(messageFunctionB ? sic_pkg::ASCII_B : sic_pkg::ASCII_A);
			end
			else if (freeDone || pingPulse)
				msgOn_q <= 1'b0;
			if (pingPulse)
			begin
				pingOn_q     <= 1'b1;
				pingNameStep <= 1'b0;
			end
			else
			begin
				if (pingOn_q && blinkCnt_q == 24'h000000 && !blink_q)
					pingNameStep <= 1'b1;
				// newest screen wins; a lone timeout must never be lost
				if (freeDone || messagePulse)
					pingOn_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// screen selection, priority highest first
	logic [3:0] screenD;

	always_comb
	begin
		if (setupTransfer)
			screenD = sic_pkg::SCR_TRANSFER;
		else if (setupWait)
			screenD = sic_pkg::SCR_WAIT;
		else if (errorOn_q && (locked_q || !freeDone))
			screenD = sic_pkg::SCR_ERROR;
		else if (startPhase)
			screenD = bootScreen(bootIdx_q, configPresent);
		else if (pingOn_q)
			screenD = sic_pkg::SCR_PING;
		else if (msgOn_q)
			screenD = sic_pkg::SCR_MESSAGE;
		else if (levelRequest || (bootDone_q && !configPresent))
			screenD = sic_pkg::SCR_LEVEL;
		else
			screenD = sic_pkg::SCR_FIELD;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			screen        <= sic_pkg::SCR_TYPE;
			displayEnable <= 1'b0;
			displayRotate <= 1'b0;
		end
		else
		begin
			screen        <= screenD;
			displayEnable <= !(displayOffCfg && screenD == sic_pkg::SCR_FIELD);
			displayRotate <= displayRotateCfg && screenD == sic_pkg::SCR_FIELD;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tagH         <= 8'h00;
			tagV         <= 8'h00;
			levelH       <= 8'sh00;
			levelV       <= 8'sh00;
			pairLetter   <= 8'h00;
			pairNumber   <= 7'h00;
			pairSubIndex <= 4'h0;
		end
		else
		begin
			tagH         <= sic_pkg::ASCII_H;
			tagV         <= sic_pkg::ASCII_V;
			levelH       <= tiltH;
			levelV       <= tiltV;
			pairLetter   <= activeFunctionB ? sic_pkg::ASCII_B : sic_pkg::ASCII_A;
			pairNumber   <= activePair;
			pairSubIndex <= activeSubIndex;
		end
	end
endmodule // sic_status_indicator
`default_nettype wire

// ---- dv/sic_operator_model.sv ----
// Purpose: operator watching the lamps of function A
// Assumes: lamps sampled on each rising sys_clk edge
// Notes:   only the lit run length of LED2 is judged, enough to time the flash
`timescale 1ns/1ps
`default_nettype none
module sic_operator_model (
	input  wire logic       sys_clk,
	input  wire logic [5:0] ledOn,
	output var  logic [7:0] runLen,
	output var  logic [7:0] lastRun
);
	always_ff @(posedge sys_clk)
	begin
		runLen <= ledOn[1] ? runLen + 8'h01 : 8'h00;
		if (!ledOn[1] && runLen != 8'h00)
			lastRun <= runLen;
	end
endmodule // sic_operator_model
`default_nettype wire

// ---- dv/sic_status_indicator_checker.sv ----
// Purpose: port checks of the status indicator
// Assumes: one clock, async active-low reset
// Notes:   lamp checks wait three cycles after reset for the pipeline
`timescale 1ns/1ps
`default_nettype none
module sic_status_indicator_checker #(
	parameter int unsigned AUTOMATIC_ERROR_RESET_CYC = 40
) (
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic [1:0] outputsOn,
	input wire logic [1:0] interlockActive,
	input wire logic [1:0] interlockBlocked,
	input wire logic [1:0] linkedEnabled,
	input wire logic [1:0] fieldOccupied,
	input wire logic [1:0] warnInterrupted,
	input wire logic       errorPulse,
	input wire logic       errorLocking,
	input wire logic       displayOffCfg,
	input wire logic       displayRotateCfg,
	input wire logic [5:0] ledOn,
	input wire logic [1:0] ledGreen,
	input wire logic [3:0] screen,
	input wire logic [7:0] tagH,
	input wire logic [7:0] tagV,
	input wire logic       displayEnable,
	input wire logic       displayRotate,
	input wire logic       automaticErrorReset,
	input wire logic       errorLatched,
	input wire logic       lockedError
);
	logic [1:0]  upCnt;
	logic [15:0] errCnt;
	wire logic   readyA = interlockActive[0] && interlockBlocked[0] && linkedEnabled[0]
		&& !fieldOccupied[0];
	wire logic   darkA  = !(interlockActive[0] && interlockBlocked[0]) && !fieldOccupied[0];
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			upCnt <= 2'h0;
		else if (upCnt != 2'h3)
			upCnt <= upCnt + 2'h1;
	end
	// cycles since the last accepted error
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			errCnt <= 16'h0000;
		else if (errorPulse && !lockedError)
			errCnt <= 16'h0001;
		else if (errCnt != 16'hFFFF)
			errCnt <= errCnt + 16'h0001;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence lampReady;
		upCnt == 2'h3;
	endsequence
	sequence errTaken;
		errorPulse && !errorLocking && !lockedError;
	endsequence
	blue_lamps_a: assert property (lampReady |-> ledOn[2] == $past(warnInterrupted[0], 2)
		&& ledOn[3] == $past(warnInterrupted[1], 2)) else $error("blue lamp wrong");
	yellow_dark_a: assert property (lampReady ##0 $past(darkA, 2) |-> !ledOn[1])
		else $error("yellow lamp lit");
	yellow_ready_a: assert property (lampReady ##0 $past(readyA, 2) |-> ledOn[1])
		else $error("yellow lamp dark");
	green_lamps_a: assert property ((!errorLatched && !lockedError)[*4] ##0 lampReady
		|-> ledOn[0] && ledOn[5] && ledGreen == $past(outputsOn, 2)) else $error("lamp colour");
	error_taken_a: assert property (errTaken |-> ##[1:2] errorLatched)
		else $error("error not latched");
	reset_timing_a: assert property (automaticErrorReset |-> errCnt >= AUTOMATIC_ERROR_RESET_CYC
		&& errCnt <= AUTOMATIC_ERROR_RESET_CYC + 4) else $error("auto reset early or late");
	reset_pulse_a: assert property (automaticErrorReset |=> !automaticErrorReset
		&& !errorLatched) else $error("auto reset pulse");
	locked_hold_a: assert property (lockedError |=> lockedError && !automaticErrorReset)
		else $error("locked error left");
	level_tags_a: assert property (screen == sic_pkg::SCR_LEVEL |-> tagH == sic_pkg::ASCII_H
		&& tagV == sic_pkg::ASCII_V) else $error("level tags");
	display_cfg_a: assert property ((screen == sic_pkg::SCR_FIELD && $stable(displayOffCfg)
		&& $stable(displayRotateCfg))[*3] |-> displayEnable == !displayOffCfg
		&& displayRotate == displayRotateCfg) else $error("display config");
endmodule // sic_status_indicator_checker
bind sic_status_indicator sic_status_indicator_checker #(.AUTOMATIC_ERROR_RESET_CYC(AUTOMATIC_ERROR_RESET_CYC)) chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .outputsOn(outputsOn),
	.interlockActive(interlockActive), .interlockBlocked(interlockBlocked),
	.linkedEnabled(linkedEnabled), .fieldOccupied(fieldOccupied),
	.warnInterrupted(warnInterrupted), .errorPulse(errorPulse), .errorLocking(errorLocking),
	.displayOffCfg(displayOffCfg), .displayRotateCfg(displayRotateCfg), .ledOn(ledOn),
	.ledGreen(ledGreen), .screen(screen), .tagH(tagH), .tagV(tagV),
	.displayEnable(displayEnable), .displayRotate(displayRotate),
	.automaticErrorReset(automaticErrorReset), .errorLatched(errorLatched),
	.lockedError(lockedError)
);
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench of the status indicator
// Assumes: short sim counts, inputs driven at the falling edge
// Notes:   field kept occupied during non-locking error tests so the free timeout stays away
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int DWELL = 8;
	localparam int FREE  = 20;
	logic sys_clk = 1'b0, reset_n = 1'b0;
	logic [1:0] outputsOn = 2'h0, interlockActive = 2'h0, interlockBlocked = 2'h0;
	logic [1:0] linkedEnabled = 2'h3, fieldOccupied = 2'h0, warnInterrupted = 2'h0;
	logic startPhase = 1'b1, configPresent = 1'b0, setupWait = 1'b0, setupTransfer = 1'b0;
	logic levelRequest = 1'b0, pingPulse = 1'b0, messagePulse = 1'b0;
	logic messageFromDevice = 1'b0, messageFunctionB = 1'b0, errorPulse = 1'b0;
	logic errorLocking = 1'b0, activeFunctionB = 1'b1, displayOffCfg = 1'b0;
	logic displayRotateCfg = 1'b0;
	logic [2:0] errorClass = 3'h0;
	logic [11:0] errorNumber = 12'h000;
	logic [6:0] activePair = 7'h05;
	logic [3:0] activeSubIndex = 4'h2;
	logic signed [7:0] tiltH = 8'hFD, tiltV = 8'h09, levelH, levelV;
	logic [5:0] ledOn;
	logic [1:0] ledGreen;
	logic [3:0] screen, pairSubIndex;
	logic [7:0] prefixChar, classChar, tagH, tagV, pairLetter, runLen, lastRun;
	logic [11:0] codeNumber;
	logic [6:0] pairNumber;
	logic pingNameStep, displayEnable, displayRotate, automaticErrorReset;
	logic errorLatched, lockedError;
	int err_total = 0, total_checks = 0, n;
	logic [7:0] letters [5] = '{8'h46, 8'h45, 8'h55, 8'h49, 8'h50};
	sic_status_indicator #(.AUTOMATIC_ERROR_RESET_CYC(40), .FREE_CYC(FREE), .DWELL_CYC(DWELL),
		.BLINK_HALF(4)) dut (
		.sys_clk, .reset_n, .outputsOn, .interlockActive, .interlockBlocked, .linkedEnabled,
		.fieldOccupied, .warnInterrupted, .startPhase, .configPresent, .setupWait,
		.setupTransfer, .levelRequest, .pingPulse, .messagePulse, .messageFromDevice,
		.messageFunctionB, .errorPulse, .errorLocking, .errorClass, .errorNumber,
		.activeFunctionB, .activePair, .activeSubIndex, .tiltH, .tiltV, .displayOffCfg,
		.displayRotateCfg, .ledOn, .ledGreen, .screen, .pingNameStep, .prefixChar, .classChar,
		.codeNumber, .tagH, .tagV, .levelH, .levelV, .pairLetter, .pairNumber, .pairSubIndex,
		.displayEnable, .displayRotate, .automaticErrorReset, .errorLatched, .lockedError);
	sic_operator_model eye (.sys_clk, .ledOn, .runLen, .lastRun);
	always #20 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait; the count doubles as a dwell measure
	task automatic wait_screen(input logic [3:0] s);
		n = 0;
		while (screen !== s && n < 200)
		begin
			cyc(1);
			n++;
		end
		check(screen, s);
	endtask
	task automatic do_reset(input logic cfg);
		reset_n = 1'b0;
		configPresent = cfg;
		startPhase = 1'b1;
		cyc(16);
		reset_n = 1'b1;
	endtask
	task automatic boot(input logic cfg);
		logic [3:0] seq[$];
		seq = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
		if (cfg)
			seq = {seq, 4'h7, 4'h8, 4'h9, 4'h0, 4'h1};
		else
			seq = {seq, 4'h6, 4'h0, 4'h1};
		do_reset(cfg);
		foreach (seq[i])
		begin
			wait_screen(seq[i]);
			if (i > 1)
				check(n, DWELL);
		end
		startPhase = 1'b0;
		wait_screen(cfg ? 4'hA : 4'h9);
	endtask
	task automatic led_case(input logic [1:0] o, a, b, w, input logic [5:0] l, input logic [1:0] g);
		outputsOn = o;
		interlockActive = a;
		interlockBlocked = b;
		warnInterrupted = w;
		cyc(3);
		check(ledOn, l);
		check(ledGreen, g);
	endtask
	task automatic pulse_error(input logic lock, input logic [2:0] cls, input logic [11:0] num);
		errorLocking = lock;
		errorClass = cls;
		errorNumber = num;
		errorPulse = 1'b1;
		cyc(1);
		errorPulse = 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(5000);
		err_total++;
		end_of_test();
	end
	initial
	begin
		boot(1'b0);
		check({tagH, tagV, levelH, levelV}, 32'h4856FD09);
		led_case(2'h3, 2'h0, 2'h0, 2'h0, 6'h21, 2'h3);
		led_case(2'h0, 2'h0, 2'h0, 2'h3, 6'h2D, 2'h0);
		led_case(2'h0, 2'h3, 2'h3, 2'h0, 6'h33, 2'h0);
		led_case(2'h0, 2'h3, 2'h0, 2'h0, 6'h21, 2'h0);
		fieldOccupied = 2'h3;
		cyc(24);
		check(lastRun, 8'h04);
		fieldOccupied = 2'h0;
		boot(1'b1);
		check({pairLetter, 1'b0, pairNumber, pairSubIndex}, {8'h42, 8'h05, 4'h2});
		setupWait = 1'b1;
		wait_screen(4'hB);
		setupWait = 1'b0;
		setupTransfer = 1'b1;
		wait_screen(4'hC);
		setupTransfer = 1'b0;
		pingPulse = 1'b1;
		cyc(1);
		pingPulse = 1'b0;
		check(pingNameStep, 1'b0);
		wait_screen(4'hD);
		cyc(12);
		check(pingNameStep, 1'b1);
		for (int d = 0; d < 2; d++)
		begin
			messageFunctionB = !d[0];
			messageFromDevice = d[0];
			messagePulse = 1'b1;
			cyc(1);
			messagePulse = 1'b0;
			wait_screen(4'hE);
			check(prefixChar, d[0] ? 8'h44 : 8'h42);
		end
		wait_screen(4'hA);
		check(n >= FREE - 3 && n <= FREE + 4, 1'b1);
		fieldOccupied = 2'h3;
		outputsOn = 2'h3;
		for (int k = 0; k < 5; k++)
		begin
			pulse_error(1'b0, 3'(k), 12'h100 + 12'(k));
			wait_screen(4'hF);
			check({classChar, codeNumber}, {letters[k], 12'h100 + 12'(k)});
		end
		cyc(3);
		check(ledGreen, 2'h0);
		n = 0;
		while (automaticErrorReset !== 1'b1 && n < 60)
		begin
			cyc(1);
			n++;
		end
		check(automaticErrorReset, 1'b1);
		cyc(2);
		check(errorLatched, 1'b0);
		fieldOccupied = 2'h0;
		wait_screen(4'hA);
		displayOffCfg = 1'b1;
		cyc(4);
		check(displayEnable, 1'b0);
		displayOffCfg = 1'b0;
		displayRotateCfg = 1'b1;
		cyc(4);
		check({displayEnable, displayRotate}, 2'h3);
		pulse_error(1'b1, 3'h0, 12'h0FF);
		cyc(80);
		check({lockedError, classChar}, {1'b1, 8'h46});
		pulse_error(1'b0, 3'h1, 12'h001);
		cyc(3);
		check({lockedError, classChar, codeNumber}, {1'b1, 8'h46, 12'h0FF});
		do_reset(1'b1);
		cyc(2);
		check(lockedError, 1'b0);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
